// >>> hpv_pkg.sv
// shared constants for the host port and vector logic
package hpv_pkg;
	// direct register select codes
	localparam logic [1:0] HPV_SEL_PORT_C = 2'h0;
	localparam logic [1:0] HPV_SEL_PORT_B = 2'h1;
	localparam logic [1:0] HPV_SEL_PORT_A = 2'h2;
	localparam logic [1:0] HPV_SEL_CONTROL = 2'h3;
	// pointer targets
	localparam logic [5:0] HPV_REG_MASTER = 6'h00;
	localparam logic [5:0] HPV_REG_VEC_A = 6'h02;
	localparam logic [5:0] HPV_REG_VEC_B = 6'h03;
	localparam logic [5:0] HPV_REG_VEC_CT = 6'h04;
	localparam logic [5:0] HPV_REG_SRC_BASE = 6'h08;
	localparam logic [5:0] HPV_REG_DATA_A = 6'h0D;
	localparam logic [5:0] HPV_REG_DATA_B = 6'h0E;
	localparam logic [5:0] HPV_REG_DATA_C = 6'h0F;
	localparam logic [5:0] HPV_REG_TIMER3_RELOAD_LOW = 6'h1B;
	localparam logic [5:0] HPV_REG_TIMER1_MODE = 6'h1C;
	localparam logic [5:0] HPV_REG_TIMER2_MODE = 6'h1D;
	localparam logic [5:0] HPV_REG_TIMER3_MODE = 6'h1E;
	localparam logic [5:0] HPV_REG_POLLED_VECTOR = 6'h1F;
	// master control field positions
	localparam int HPV_BIT_GLOBAL = 7;
	localparam int HPV_BIT_CHAIN = 6;
	localparam int HPV_BIT_QUIET = 5;
	localparam int HPV_BIT_STAT_A = 4;
	localparam int HPV_BIT_STAT_B = 3;
	localparam int HPV_BIT_STAT_T = 2;
	localparam int HPV_BIT_RESET = 0;
	// per-source control field positions
	localparam int HPV_BIT_PEND = 7;
	localparam int HPV_BIT_SVC = 6;
	localparam int HPV_BIT_ENA = 5;
	// sources in fixed priority order, index 0 highest
	localparam int HPV_NUM_SRC = 5;
	localparam int HPV_SRC_CT3 = 0;
	localparam int HPV_SRC_PA = 1;
	localparam int HPV_SRC_CT2 = 2;
	localparam int HPV_SRC_PB = 3;
	localparam int HPV_SRC_CT1 = 4;
	// counter/timer status codes placed in the shared vector
	localparam logic [1:0] HPV_CT_CODE_3 = 2'h0;
	localparam logic [1:0] HPV_CT_CODE_2 = 2'h1;
	localparam logic [1:0] HPV_CT_CODE_1 = 2'h2;
	localparam logic [1:0] HPV_CT_CODE_NONE = 2'h3;
	// fixed read values
	localparam logic [7:0] HPV_READ_IN_RESET = 8'h01;
	localparam logic [7:0] HPV_NO_VECTOR = 8'hFF;
	localparam logic [7:0] HPV_BYTE_ZERO = 8'h00;
	// access state machine, one-hot
	typedef enum logic [1:0] {
		HPV_ACC_POINTER = 2'b01,
		HPV_ACC_TARGET = 2'b10
	} hpv_access_type;
endpackage

// >>> hpv_irq_cell.sv
// pending, under-service and enable bits of one interrupt source
`timescale 1ns/1ps
`default_nettype none
module hpv_irq_cell (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sys_reset,
	// control
	input wire logic freeze,
	input wire logic event_pulse,
	input wire logic wr_en,
	input wire logic wr_pend,
	input wire logic wr_svc,
	input wire logic wr_ena,
	input wire logic ack_set,
	// state
	output logic pend,
	output logic svc,
	output logic ena
);
	typedef struct packed {
		logic pend;
		logic svc;
		logic ena;
		logic held;
	} hpv_cell_type;

	hpv_cell_type cur;
	hpv_cell_type next_cur;

	// software write first, then hardware set so an event beats a clear
	always_comb begin
		next_cur = cur;
		if (sys_reset) begin
			next_cur = '0;
		end else begin
			if (wr_en) begin
				next_cur.pend = wr_pend;
				next_cur.svc = wr_svc;
				next_cur.ena = wr_ena;
			end
			if (ack_set) begin
				next_cur.svc = 1'b1;
			end
			// events during a frozen access are held, not lost
			if (freeze) begin
				next_cur.held = cur.held | event_pulse;
			end else begin
				if (event_pulse || cur.held) begin
					next_cur.pend = 1'b1;
				end
				next_cur.held = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign pend = cur.pend;
	assign svc = cur.svc;
	assign ena = cur.ena;
endmodule
`default_nettype wire

// >>> hpv_host_port.sv
// host register port, access state machine and interrupt vector logic
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - acknowledge supplies an 8-bit vector from port A, port B or timer base.
// - vector suppress set keeps the data bus undriven during acknowledge.
// - each base vector has its own status-in-vector bit adding cause bits.
// - with global enable set, base vector reads include status.
// - with global enable clear, base vector reads return the programmed value.
// - polled vector returns the acknowledge vector, or all ones if nothing pending.
// - select 00 port C, 01 port B, 10 port A, 11 control path.
// - other registers are reached by writing a 6-bit pointer then accessing.
// - two-state machine picks pointer or target; only select 11 accesses and pin reset move it.
// - any control read leaves the machine pointing at the pointer.
// - control read in pointer state returns the last pointed register.
// - in target state no pending bit sets and status stays frozen.
// - reset by read and write strobes low together or writing reset bit.
// - in reset control bits clear, only the pointer and reset bit writable, reads give 01.
// - while read strobe low with chip enabled, selected register is driven.
// - write strobe falling with chip enabled stores bus data.
// - interrupt request pulled low while an enabled source is pending and chain input is high.
// - acknowledge with a pending bit drives chain enable output low.
// - with chain input high, vector driven and under-service set on read.
// - priority fixed: timer 3, port A, timer 2, port B, timer 1.
// - global enable clear masks all pending bits from request and acknowledge.
// - block lower chain bit forces chain enable output low.
module hpv_host_port
	import hpv_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// host strobes and select
	input wire logic ce_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [1:0] register_select,
	// host data bus, split
	input wire logic [7:0] host_data_bus_in,
	output logic [7:0] host_data_bus_out,
	output logic host_data_bus_oe_n,
	// interrupt pins
	output logic irq_request_out,
	output logic irq_request_oe_n,
	input wire logic irq_acknowledge_n,
	input wire logic chain_enable_input,
	output logic chain_enable_output,
	// interrupt events, index 0 highest priority
	input wire logic [hpv_pkg::HPV_NUM_SRC-1:0] source_event,
	input wire logic [2:0] port_a_cause,
	input wire logic [2:0] port_b_cause,
	// stored values toward the port and timer logic
	output logic [7:0] port_a_data,
	output logic [7:0] port_b_data,
	output logic [7:0] port_c_data,
	output logic [7:0] timer3_reload_low_byte,
	output logic [7:0] timer1_mode_setup,
	output logic [7:0] timer2_mode_setup,
	output logic [7:0] timer3_mode_setup,
	output logic device_in_reset
);
	import hpv_pkg::*;

	typedef struct packed {
		hpv_access_type acc;
		logic [5:0] pointer;
		logic reset_bit;
		logic global_irq_enable;
		logic block_lower_chain;
		logic vector_suppress;
		logic [2:0] status_in_vector;
		logic [7:0] vec_a;
		logic [7:0] vec_b;
		logic [7:0] vec_ct;
		logic [7:0] data_a;
		logic [7:0] data_b;
		logic [7:0] data_c;
		logic [7:0] tc3_lo;
		logic [7:0] mode1;
		logic [7:0] mode2;
		logic [7:0] mode3;
		logic rd_q;
		logic wr_q;
		logic [7:0] dout;
		logic drive;
		logic [2:0] st_a;
		logic [2:0] st_b;
	} hpv_port_type;

	hpv_port_type cur;
	hpv_port_type next_cur;
	logic rst_meta;
	logic rst_n;
	logic [HPV_NUM_SRC-1:0] pend;
	logic [HPV_NUM_SRC-1:0] svc;
	logic [HPV_NUM_SRC-1:0] ena;
	logic [HPV_NUM_SRC-1:0] req;
	logic [HPV_NUM_SRC-1:0] ack_set;
	logic [HPV_NUM_SRC-1:0] src_wr;
	logic any_req;
	logic found;
	logic [2:0] top_idx;
	logic [1:0] ct_code;
	logic [7:0] ack_vector;
	logic [7:0] polled_vector;
	logic pin_reset;
	logic rd_fall;
	logic wr_fall;
	logic ctl_wr;
	logic ack_cycle;
	logic ack_read;
	logic [7:0] reg_value;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// base vector with status bits merged in
	function automatic logic [7:0] port_vec(input logic [7:0] base, input logic [2:0] cause);
		port_vec = {base[7:4], cause, base[0]};
	endfunction

	function automatic logic [7:0] ct_vec(input logic [7:0] base, input logic [1:0] code);
		ct_vec = {base[7:3], code, base[0]};
	endfunction

	// strobe edges; strobes are synchronous inputs
	assign pin_reset = !rd_n && !wr_n;
	assign rd_fall = cur.rd_q && !rd_n && !pin_reset;
	assign wr_fall = cur.wr_q && !wr_n && !pin_reset;
	assign ack_cycle = !irq_acknowledge_n;
	assign ctl_wr = wr_fall && !ce_n && !ack_cycle && (register_select == HPV_SEL_CONTROL) &&
		(cur.acc == HPV_ACC_TARGET);

	// pending sources masked by their enables and the global enable
	assign req = (pend & ena) & {HPV_NUM_SRC{cur.global_irq_enable}};
	assign any_req = |req;

	// fixed priority encoder, lowest index wins
	always_comb begin
		found = 1'b0;
		top_idx = 3'h0;
		for (int i = 0; i < HPV_NUM_SRC; i++) begin
			if (req[i] && !found) begin
				found = 1'b1;
				top_idx = 3'(i);
			end
		end
	end

	// timer code follows the highest pending timer
	always_comb begin
		if (req[HPV_SRC_CT3]) begin
			ct_code = HPV_CT_CODE_3;
		end else if (req[HPV_SRC_CT2]) begin
			ct_code = HPV_CT_CODE_2;
		end else if (req[HPV_SRC_CT1]) begin
			ct_code = HPV_CT_CODE_1;
		end else begin
			ct_code = HPV_CT_CODE_NONE;
		end
	end

	// vector that an acknowledge would return now
	always_comb begin
		if (top_idx == 3'(HPV_SRC_PA)) begin
			ack_vector = cur.status_in_vector[2] ? port_vec(cur.vec_a, cur.st_a) : cur.vec_a;
		end else if (top_idx == 3'(HPV_SRC_PB)) begin
			ack_vector = cur.status_in_vector[1] ? port_vec(cur.vec_b, cur.st_b) : cur.vec_b;
		end else begin
			ack_vector = cur.status_in_vector[0] ? ct_vec(cur.vec_ct, ct_code) : cur.vec_ct;
		end
		polled_vector = found ? ack_vector : HPV_NO_VECTOR;
	end

	// read value of the register that the pointer names
	always_comb begin
		reg_value = HPV_BYTE_ZERO;
		if (cur.pointer == HPV_REG_MASTER) begin
			reg_value[HPV_BIT_GLOBAL] = cur.global_irq_enable;
			reg_value[HPV_BIT_CHAIN] = cur.block_lower_chain;
			reg_value[HPV_BIT_QUIET] = cur.vector_suppress;
			reg_value[HPV_BIT_STAT_A] = cur.status_in_vector[2];
			reg_value[HPV_BIT_STAT_B] = cur.status_in_vector[1];
			reg_value[HPV_BIT_STAT_T] = cur.status_in_vector[0];
			reg_value[HPV_BIT_RESET] = cur.reset_bit;
		end else if (cur.pointer == HPV_REG_VEC_A) begin
			reg_value = cur.global_irq_enable ? port_vec(cur.vec_a, cur.st_a) : cur.vec_a;
		end else if (cur.pointer == HPV_REG_VEC_B) begin
			reg_value = cur.global_irq_enable ? port_vec(cur.vec_b, cur.st_b) : cur.vec_b;
		end else if (cur.pointer == HPV_REG_VEC_CT) begin
			reg_value = cur.global_irq_enable ? ct_vec(cur.vec_ct, ct_code) : cur.vec_ct;
		end else if (cur.pointer >= HPV_REG_SRC_BASE && cur.pointer < HPV_REG_SRC_BASE + 6'(HPV_NUM_SRC)) begin
			reg_value[HPV_BIT_PEND] = pend[3'(cur.pointer - HPV_REG_SRC_BASE)];
			reg_value[HPV_BIT_SVC] = svc[3'(cur.pointer - HPV_REG_SRC_BASE)];
			reg_value[HPV_BIT_ENA] = ena[3'(cur.pointer - HPV_REG_SRC_BASE)];
		end else if (cur.pointer == HPV_REG_DATA_A) begin
			reg_value = cur.data_a;
		end else if (cur.pointer == HPV_REG_DATA_B) begin
			reg_value = cur.data_b;
		end else if (cur.pointer == HPV_REG_DATA_C) begin
			reg_value = cur.data_c;
		end else if (cur.pointer == HPV_REG_TIMER3_RELOAD_LOW) begin
			reg_value = cur.tc3_lo;
		end else if (cur.pointer == HPV_REG_TIMER1_MODE) begin
			reg_value = cur.mode1;
		end else if (cur.pointer == HPV_REG_TIMER2_MODE) begin
			reg_value = cur.mode2;
		end else if (cur.pointer == HPV_REG_TIMER3_MODE) begin
			reg_value = cur.mode3;
		end else if (cur.pointer == HPV_REG_POLLED_VECTOR) begin
			reg_value = polled_vector;
		end
	end

	// acknowledge read: chain open above us and something to serve
	assign ack_read = rd_fall && ack_cycle && chain_enable_input && any_req;
	always_comb begin
		for (int i = 0; i < HPV_NUM_SRC; i++) begin
			ack_set[i] = ack_read && (top_idx == 3'(i));
			src_wr[i] = ctl_wr && !cur.reset_bit && (cur.pointer == HPV_REG_SRC_BASE + 6'(i));
		end
	end

	// one interrupt cell per source
	genvar g;
	generate
		for (g = 0; g < HPV_NUM_SRC; g++) begin : g_src
			hpv_irq_cell u_cell (
				.clk(clk),
				.rst_n(rst_n),
				.sys_reset(next_cur.reset_bit), // cleared on the edge that enters reset
				.freeze(cur.acc == HPV_ACC_TARGET),
				.event_pulse(source_event[g]),
				.wr_en(src_wr[g]),
				.wr_pend(host_data_bus_in[HPV_BIT_PEND]),
				.wr_svc(host_data_bus_in[HPV_BIT_SVC]),
				.wr_ena(host_data_bus_in[HPV_BIT_ENA]),
				.ack_set(ack_set[g]),
				.pend(pend[g]),
				.svc(svc[g]),
				.ena(ena[g])
			);
		end
	endgenerate

	// host access sequencing and register writes
	always_comb begin
		next_cur = cur;
		next_cur.rd_q = rd_n;
		next_cur.wr_q = wr_n;
		// cause bits only follow the pins while not frozen
		if (cur.acc == HPV_ACC_POINTER) begin
			next_cur.st_a = port_a_cause;
			next_cur.st_b = port_b_cause;
		end
		if (rd_n) begin
			next_cur.drive = 1'b0;
		end
		if (pin_reset) begin
			next_cur.reset_bit = 1'b1;
			next_cur.acc = HPV_ACC_POINTER;
		end else if (ack_read) begin
			next_cur.dout = ack_vector;
			next_cur.drive = !cur.vector_suppress;
		end else if (rd_fall && !ce_n && !ack_cycle) begin
			next_cur.drive = 1'b1;
			if (cur.reset_bit) begin
				next_cur.dout = HPV_READ_IN_RESET;
			end else if (register_select == HPV_SEL_PORT_C) begin
				next_cur.dout = cur.data_c;
			end else if (register_select == HPV_SEL_PORT_B) begin
				next_cur.dout = cur.data_b;
			end else if (register_select == HPV_SEL_PORT_A) begin
				next_cur.dout = cur.data_a;
			end else begin
				next_cur.dout = reg_value;
			end
			if (register_select == HPV_SEL_CONTROL) begin
				next_cur.acc = HPV_ACC_POINTER;
			end
		end else if (wr_fall && !ce_n && !ack_cycle) begin
			if (register_select == HPV_SEL_CONTROL) begin
				if (cur.acc == HPV_ACC_POINTER) begin
					next_cur.pointer = host_data_bus_in[5:0];
					next_cur.acc = HPV_ACC_TARGET;
				end else begin
					next_cur.acc = HPV_ACC_POINTER;
					if (cur.pointer == HPV_REG_MASTER) begin
						next_cur.reset_bit = host_data_bus_in[HPV_BIT_RESET];
					end
					// everything but the reset bit is locked while in reset
					if (!cur.reset_bit) begin
						if (cur.pointer == HPV_REG_MASTER) begin
							next_cur.global_irq_enable = host_data_bus_in[HPV_BIT_GLOBAL];
							next_cur.block_lower_chain = host_data_bus_in[HPV_BIT_CHAIN];
							next_cur.vector_suppress = host_data_bus_in[HPV_BIT_QUIET];
							next_cur.status_in_vector = {host_data_bus_in[HPV_BIT_STAT_A],
								host_data_bus_in[HPV_BIT_STAT_B], host_data_bus_in[HPV_BIT_STAT_T]};
						end else if (cur.pointer == HPV_REG_VEC_A) begin
							next_cur.vec_a = host_data_bus_in;
						end else if (cur.pointer == HPV_REG_VEC_B) begin
							next_cur.vec_b = host_data_bus_in;
						end else if (cur.pointer == HPV_REG_VEC_CT) begin
							next_cur.vec_ct = host_data_bus_in;
						end else if (cur.pointer == HPV_REG_DATA_A) begin
							next_cur.data_a = host_data_bus_in;
						end else if (cur.pointer == HPV_REG_DATA_B) begin
							next_cur.data_b = host_data_bus_in;
						end else if (cur.pointer == HPV_REG_DATA_C) begin
							next_cur.data_c = host_data_bus_in;
						end else if (cur.pointer == HPV_REG_TIMER3_RELOAD_LOW) begin
							next_cur.tc3_lo = host_data_bus_in;
						end else if (cur.pointer == HPV_REG_TIMER1_MODE) begin
							next_cur.mode1 = host_data_bus_in;
						end else if (cur.pointer == HPV_REG_TIMER2_MODE) begin
							next_cur.mode2 = host_data_bus_in;
						end else if (cur.pointer == HPV_REG_TIMER3_MODE) begin
							next_cur.mode3 = host_data_bus_in;
						end
					end
				end
			end else if (!cur.reset_bit) begin
				// direct data writes
				if (register_select == HPV_SEL_PORT_C) begin
					next_cur.data_c = host_data_bus_in;
				end else if (register_select == HPV_SEL_PORT_B) begin
					next_cur.data_b = host_data_bus_in;
				end else begin
					next_cur.data_a = host_data_bus_in;
				end
			end
		end
		// reset forces every control bit to zero
		if (next_cur.reset_bit) begin
			next_cur.global_irq_enable = 1'b0;
			next_cur.block_lower_chain = 1'b0;
			next_cur.vector_suppress = 1'b0;
			next_cur.status_in_vector = 3'h0;
			next_cur.vec_a = HPV_BYTE_ZERO;
			next_cur.vec_b = HPV_BYTE_ZERO;
			next_cur.vec_ct = HPV_BYTE_ZERO;
			next_cur.tc3_lo = HPV_BYTE_ZERO;
			next_cur.mode1 = HPV_BYTE_ZERO;
			next_cur.mode2 = HPV_BYTE_ZERO;
			next_cur.mode3 = HPV_BYTE_ZERO;
		end
	end

	// power-up leaves the device in reset, as after a pin reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
			cur.acc <= HPV_ACC_POINTER;
			cur.reset_bit <= 1'b1;
			cur.rd_q <= 1'b1;
			cur.wr_q <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// bus drive stops as soon as the read strobe rises
	assign host_data_bus_out = cur.dout;
	assign host_data_bus_oe_n = !(cur.drive && !rd_n);
	// open-drain request, only while no higher device blocks us
	assign irq_request_out = 1'b0;
	assign irq_request_oe_n = !(any_req && chain_enable_input);
	// chain closes on service, on acknowledge with pending, or on command
	assign chain_enable_output = chain_enable_input && !cur.block_lower_chain &&
		!(|svc) && !(ack_cycle && any_req);
	assign port_a_data = cur.data_a;
	assign port_b_data = cur.data_b;
	assign port_c_data = cur.data_c;
	assign timer3_reload_low_byte = cur.tc3_lo;
	assign timer1_mode_setup = cur.mode1;
	assign timer2_mode_setup = cur.mode2;
	assign timer3_mode_setup = cur.mode3;
	assign device_in_reset = cur.reset_bit;
endmodule
`default_nettype wire

// >>> hpv_host_port_monitor.sv
// concurrent checks on the pins of the host port
`timescale 1ns/1ps
`default_nettype none
module hpv_host_port_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// host strobes
	input wire logic ce_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic irq_acknowledge_n,
	// bus and interrupt pins
	input wire logic [7:0] host_data_bus_out,
	input wire logic host_data_bus_oe_n,
	input wire logic irq_request_out,
	input wire logic irq_request_oe_n,
	input wire logic chain_enable_input,
	input wire logic chain_enable_output,
	// stored state
	input wire logic device_in_reset,
	input wire logic [7:0] timer1_mode_setup,
	input wire logic [7:0] port_a_data
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	chk_reset_read_value: assert property (
		device_in_reset && !host_data_bus_oe_n && wr_n && irq_acknowledge_n |-> host_data_bus_out == 8'h01)
		else $error("read in reset did not return 01");
	chk_drive_only_reading: assert property (
		!host_data_bus_oe_n |-> !rd_n && (!ce_n || !irq_acknowledge_n))
		else $error("bus driven without read strobe");
	chk_read_answers: assert property (
		$fell(rd_n) && !ce_n && wr_n && irq_acknowledge_n |=> rd_n || !host_data_bus_oe_n)
		else $error("read strobe not answered");
	chk_irq_open_drain: assert property (
		irq_request_out == 1'h0)
		else $error("request pin driven high");
	chk_irq_not_in_reset: assert property (
		!irq_request_oe_n |-> !device_in_reset)
		else $error("request raised while control bits cleared");
	chk_chain_blocked: assert property (
		!chain_enable_input |-> !chain_enable_output)
		else $error("chain output high with chain input low");
	chk_reset_chain_pass: assert property (
		device_in_reset |-> chain_enable_output == chain_enable_input)
		else $error("chain not passed through in reset");
	chk_reset_writes_ignored: assert property (
		$past(device_in_reset) && device_in_reset |-> $stable(timer1_mode_setup) && $stable(port_a_data))
		else $error("register changed while in reset");
	chk_pin_reset_entry: assert property (
		!rd_n && !wr_n |=> device_in_reset)
		else $error("both strobes low did not reset");
endmodule
bind hpv_host_port hpv_host_port_monitor hpv_host_port_monitor_inst (.clk(clk), .rst_b(rst_b), .ce_n(ce_n),
	.rd_n(rd_n), .wr_n(wr_n), .irq_acknowledge_n(irq_acknowledge_n), .host_data_bus_out(host_data_bus_out),
	.host_data_bus_oe_n(host_data_bus_oe_n), .irq_request_out(irq_request_out), .irq_request_oe_n(irq_request_oe_n),
	.chain_enable_input(chain_enable_input), .chain_enable_output(chain_enable_output),
	.device_in_reset(device_in_reset), .timer1_mode_setup(timer1_mode_setup), .port_a_data(port_a_data));
`default_nettype wire

// >>> hpv_host_model.sv
// microprocessor side: bus cycles, acknowledge and data bus resolution
`timescale 1ns/1ps
`default_nettype none
module hpv_host_model (
	// clock
	input wire logic clk,
	// strobes toward the device
	output logic ce_n,
	output logic rd_n,
	output logic wr_n,
	output logic [1:0] register_select,
	output logic irq_acknowledge_n,
	// data bus halves
	input wire logic [7:0] host_data_bus_out,
	input wire logic host_data_bus_oe_n,
	output logic [7:0] host_data_bus_in
);
	logic [7:0] drive_val;
	logic drive_on;
	logic [7:0] last_val;
	// a released bus shows the inverse of its last level, so stale data never matches
	assign host_data_bus_in = !host_data_bus_oe_n ? host_data_bus_out : drive_on ? drive_val : ~last_val;
	always @(posedge clk) last_val <= host_data_bus_in;
	initial begin
		ce_n = 1;
		rd_n = 1;
		wr_n = 1;
		register_select = 2'h0;
		irq_acknowledge_n = 1;
		drive_on = 0;
		drive_val = 8'h00;
		last_val = 8'h00;
	end
	// one access: strobe held two edges, data taken at the second, all released together
	task automatic access(input logic wr, input logic [1:0] sel, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#1;
		ce_n = 0;
		register_select = sel;
		drive_val = d;
		drive_on = wr;
		rd_n = wr;
		wr_n = !wr;
		repeat (2) @(posedge clk);
		q = host_data_bus_in;
		#1;
		rd_n = 1;
		wr_n = 1;
		ce_n = 1;
		drive_on = 0;
	endtask
	// acknowledge cycle; read strobe lowered one cycle into it
	task automatic acknowledge(output logic [7:0] q, output logic oe);
		@(posedge clk);
		#1;
		irq_acknowledge_n = 0;
		@(posedge clk);
		#1;
		rd_n = 0;
		repeat (2) @(posedge clk);
		q = host_data_bus_in;
		oe = host_data_bus_oe_n;
		#1;
		rd_n = 1;
		@(posedge clk);
		#1;
		irq_acknowledge_n = 1;
	endtask
	// both strobes low for one edge forces the device into reset
	task automatic pin_reset();
		@(posedge clk);
		#1;
		rd_n = 0;
		wr_n = 0;
		@(posedge clk);
		#1;
		rd_n = 1;
		wr_n = 1;
	endtask
endmodule
`default_nettype wire

// >>> test_hpv_host_port.sv
// self-checking bench for the host port and vector logic
`timescale 1ns/1ps
`default_nettype none
module test_hpv_host_port;
	import hpv_pkg::*;
	logic clk, rst_b, ce_n, rd_n, wr_n, oe_n, irq_out, irq_oe_n, ack_n, cei, ceo, in_rst, oe;
	logic [1:0] sel;
	logic [2:0] cause_a, cause_b;
	logic [4:0] src_ev;
	logic [7:0] din, dout, pa, pb, pc, t3r, t1m, t2m, t3m, q;
	int failures, tests_run;
	hpv_host_port hpv_host_port_inst (.clk(clk), .rst_b(rst_b), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n),
		.register_select(sel), .host_data_bus_in(din), .host_data_bus_out(dout), .host_data_bus_oe_n(oe_n),
		.irq_request_out(irq_out), .irq_request_oe_n(irq_oe_n), .irq_acknowledge_n(ack_n),
		.chain_enable_input(cei), .chain_enable_output(ceo), .source_event(src_ev), .port_a_cause(cause_a),
		.port_b_cause(cause_b), .port_a_data(pa), .port_b_data(pb), .port_c_data(pc),
		.timer3_reload_low_byte(t3r), .timer1_mode_setup(t1m), .timer2_mode_setup(t2m),
		.timer3_mode_setup(t3m), .device_in_reset(in_rst));
	hpv_host_model hpv_host_model_inst (.clk(clk), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n), .register_select(sel),
		.irq_acknowledge_n(ack_n), .host_data_bus_out(dout), .host_data_bus_oe_n(oe_n), .host_data_bus_in(din));
	// compare and count
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// two-step control access: pointer first, then target
	task automatic wreg(input logic [5:0] a, input logic [7:0] v);
		hpv_host_model_inst.access(1, HPV_SEL_CONTROL, {2'h0, a}, q);
		hpv_host_model_inst.access(1, HPV_SEL_CONTROL, v, q);
	endtask
	task automatic rreg(input logic [5:0] a);
		hpv_host_model_inst.access(1, HPV_SEL_CONTROL, {2'h0, a}, q);
		hpv_host_model_inst.access(0, HPV_SEL_CONTROL, 8'h00, q);
	endtask
	task automatic pulse(input logic [4:0] m);
		@(posedge clk);
		#1;
		src_ev = m;
		@(posedge clk);
		#1;
		src_ev = 5'h00;
	endtask
	task automatic test_reset();
		rreg(HPV_REG_VEC_A);
		check("read in reset", q, HPV_READ_IN_RESET);
		wreg(HPV_REG_TIMER1_MODE, 8'h5A);
		check("write in reset", t1m, HPV_BYTE_ZERO);
		wreg(HPV_REG_MASTER, 8'h00);
		check("reset cleared", {7'h00, in_rst}, 8'h00);
		hpv_host_model_inst.access(1, HPV_SEL_CONTROL, 8'h1C, q);
		hpv_host_model_inst.pin_reset();
		check("pin reset", {7'h00, in_rst}, 8'h01);
		wreg(HPV_REG_MASTER, 8'h00);
		check("pointer state after reset", {7'h00, in_rst}, 8'h00);
		wreg(HPV_REG_MASTER, 8'h01);
		check("soft reset", {7'h00, in_rst}, 8'h01);
		wreg(HPV_REG_MASTER, 8'h00);
		$display("test_reset done");
	endtask
	task automatic test_access();
		hpv_host_model_inst.access(1, HPV_SEL_PORT_A, 8'hA1, q);
		hpv_host_model_inst.access(1, HPV_SEL_PORT_B, 8'hB2, q);
		hpv_host_model_inst.access(1, HPV_SEL_PORT_C, 8'hC3, q);
		check("port a", pa, 8'hA1);
		check("port b", pb, 8'hB2);
		check("port c", pc, 8'hC3);
		hpv_host_model_inst.access(0, HPV_SEL_PORT_B, 8'h00, q);
		check("direct read b", q, 8'hB2);
		wreg(HPV_REG_TIMER1_MODE, 8'h5A);
		check("timer1 mode", t1m, 8'h5A);
		wreg(HPV_REG_TIMER3_RELOAD_LOW, 8'h3C);
		check("timer3 reload", t3r, 8'h3C);
		wreg(HPV_REG_TIMER3_MODE, 8'hE1);
		check("timer3 mode", t3m, 8'hE1);
		rreg(HPV_REG_DATA_C);
		check("data c by pointer", q, 8'hC3);
		hpv_host_model_inst.access(0, HPV_SEL_CONTROL, 8'h00, q);
		check("repeat read", q, 8'hC3);
		hpv_host_model_inst.access(1, HPV_SEL_CONTROL, 8'h1D, q);
		hpv_host_model_inst.access(1, HPV_SEL_PORT_C, 8'h77, q);
		hpv_host_model_inst.access(1, HPV_SEL_CONTROL, 8'h66, q);
		check("direct write keeps state", t2m, 8'h66);
		check("port c rewrite", pc, 8'h77);
		$display("test_access done");
	endtask
	task automatic test_vector();
		rreg(HPV_REG_POLLED_VECTOR);
		check("polled idle", q, HPV_NO_VECTOR);
		wreg(HPV_REG_VEC_A, 8'h40);
		wreg(HPV_REG_VEC_CT, 8'h80);
		wreg(HPV_REG_SRC_BASE, 8'h20);
		wreg(HPV_REG_SRC_BASE + 6'h01, 8'h20);
		wreg(HPV_REG_MASTER, 8'h14);
		pulse(5'h02);
		check("masked request", {7'h00, irq_oe_n}, 8'h01);
		rreg(HPV_REG_VEC_A);
		check("raw vector", q, 8'h40);
		wreg(HPV_REG_MASTER, 8'h94);
		check("request", {7'h00, irq_oe_n}, 8'h00);
		rreg(HPV_REG_VEC_A);
		check("vector with status", q, 8'h4A);
		pulse(5'h01);
		rreg(HPV_REG_POLLED_VECTOR);
		check("polled priority", q, 8'h80);
		hpv_host_model_inst.acknowledge(q, oe);
		check("ack vector", q, 8'h80);
		check("chain out in service", {7'h00, ceo}, 8'h00);
		rreg(HPV_REG_SRC_BASE);
		check("under service set", q, 8'hE0);
		wreg(HPV_REG_SRC_BASE, 8'h20);
		rreg(HPV_REG_POLLED_VECTOR);
		check("next vector", q, 8'h4A);
		check("chain out idle", {7'h00, ceo}, 8'h01);
		wreg(HPV_REG_MASTER, 8'hD4);
		check("block lower chain", {7'h00, ceo}, 8'h00);
		wreg(HPV_REG_MASTER, 8'hB4);
		hpv_host_model_inst.acknowledge(q, oe);
		check("vector suppressed", {7'h00, oe}, 8'h01);
		wreg(HPV_REG_SRC_BASE + 6'h01, 8'h20);
		hpv_host_model_inst.access(1, HPV_SEL_CONTROL, 8'h09, q);
		pulse(5'h02);
		check("frozen in target state", {7'h00, irq_oe_n}, 8'h01);
		hpv_host_model_inst.access(0, HPV_SEL_CONTROL, 8'h00, q);
		pulse(5'h00);
		check("held event lands", {7'h00, irq_oe_n}, 8'h00);
		$display("test_vector done");
	endtask
	// single place where the run ends
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always #10 clk = ~clk;
	initial begin
		clk = 0;
		rst_b = 0;
		cei = 1;
		src_ev = 5'h00;
		cause_a = 3'h5;
		cause_b = 3'h2;
		failures = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		#1;
		rst_b = 1;
		repeat (3) @(posedge clk);
		test_reset();
		test_access();
		test_vector();
		give_verdict();
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule
`default_nettype wire
